// ### design/mccrtc_clkdiv.sv
`timescale 1ns/100ps
`default_nettype none
module mccrtc_clkdiv (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    mccrtc_ctl_if.cdiv ctl
);
    import mccrtc_pkg::*;

    logic [4:0] div_q;
    logic [4:0] div_d;
    logic cpu_tap;
    logic cpu_clk_q;
    logic bus_clk_q;
    logic clk_out_q;

    // Free running synchronous count of oscillator divisions
    assign div_d = div_q + 5'h01;

    // Slow codes are bit-reversed: 00,10,01,11 give /4,/8,/16,/32
    assign cpu_tap = !ctl.slow_mode ? div_q[0] :                    // [R2]
                     (ctl.slow_div == 2'h0) ? div_q[1] :           // [R3]
                     (ctl.slow_div == 2'h2) ? div_q[2] :
                     (ctl.slow_div == 2'h1) ? div_q[3] : div_q[4];

    // Each output has its own flop so the three run side by side [R1]
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            div_q <= 5'h00;
            cpu_clk_q <= 1'b0;
            bus_clk_q <= 1'b0;
            clk_out_q <= 1'b0;
        end else begin
            div_q <= div_d;
            bus_clk_q <= div_q[0];                                  // [R4]
            if (!ctl.cpu_hold) begin
                cpu_clk_q <= cpu_tap;
            end
            if (!ctl.clk_out_en) begin
                clk_out_q <= 1'b0;
            end else if (!ctl.clk_out_hold) begin                  // [R6]
                clk_out_q <= div_q[0];                              // [R5]
            end
        end
    end

    assign ctl.cpu_clk = cpu_clk_q;
    assign ctl.bus_clk = bus_clk_q;
    assign ctl.clk_out = clk_out_q;
endmodule : mccrtc_clkdiv
`default_nettype wire

// ### design/mccrtc_ctl_if.sv
`timescale 1ns/100ps
`default_nettype none
interface mccrtc_ctl_if;
    // Time base control and event
    mccrtc_pkg::mccrtc_sel_type tb_select;
    logic tb_run;
    logic period_end;
    // Clock divider control and clocks
    logic slow_mode;
    mccrtc_pkg::mccrtc_sel_type slow_div;
    logic clk_out_en;
    logic clk_out_hold;
    logic cpu_hold;
    logic cpu_clk;
    logic bus_clk;
    logic clk_out;

    modport top (
        output tb_select, tb_run, slow_mode, slow_div, clk_out_en, clk_out_hold, cpu_hold,
        input period_end, cpu_clk, bus_clk, clk_out
    );
    modport tbase (
        input tb_select, tb_run,
        output period_end
    );
    modport cdiv (
        input slow_mode, slow_div, clk_out_en, clk_out_hold, cpu_hold,
        output cpu_clk, bus_clk, clk_out
    );
endinterface : mccrtc_ctl_if
`default_nettype wire

// ### design/mccrtc_map.svh
// What this block does
// R1 - CPU divider, clock-out and time base run independently and together.
// R2 - Slow mode bit 0 gives CPU clock at oscillator/2; 1 uses slow divider field.
// R3 - Slow divider codes 00,10,01,11 divide oscillator by 4,8,16,32.
// R4 - Peripheral bus clock is always oscillator/2, untouched by CPU divider.
// R5 - Clock-out enable drives oscillator/2 onto the alternate-function pin.
// R6 - Clock-out pin stops toggling during active-halt.
// R7 - Time base periods are 32000, 64000, 160000, 400000 oscillator counts.
// R8 - A new time base select takes effect only from the next period.
// R9 - Period end sets flag bit 0; a read of the register clears it.
// R10 - Time base interrupt requires flag, enable bit and CPU mask inactive.
// R11 - Halt with time base interrupt enabled enters active-halt, not full halt.
// R12 - Bits 7:4 read zero; reset value 01h with flag set.
// R13 - Wait mode leaves time base running; its interrupt exits wait.
// R14 - Active-halt keeps counter running, registers frozen; interrupt exits it.
// R15 - Full halt freezes counter and registers; only other interrupts end it.
// R16 - Software must not use bit set/clear instructions on the register.
// R17 - A period end coinciding with a register read keeps the flag set.
`ifndef MCCRTC_MAP_SVH
`define MCCRTC_MAP_SVH

// Register indices; byte address is four times the index
`define MCCRTC_IDX_MISC 8'h20
`define MCCRTC_IDX_CTRL 8'h29
`define MCCRTC_IDX_IRQ_STATUS 8'h2C
`define MCCRTC_IDX_IRQ_MASK 8'h2D

// Field positions
`define MCCRTC_CTRL_FLAG 0
`define MCCRTC_CTRL_IRQ_EN 1
`define MCCRTC_CTRL_TB_LO 2
`define MCCRTC_CTRL_TB_HI 3
`define MCCRTC_MISC_SMS 0
`define MCCRTC_MISC_DIV_LO 1
`define MCCRTC_MISC_DIV_HI 2
`define MCCRTC_MISC_CLKOUT 5

// Reset values
`define MCCRTC_CTRL_RESET 8'h01
`define MCCRTC_MISC_RESET 8'h00

// Time base period lengths in oscillator cycles
`define MCCRTC_TB_COUNT0 32000
`define MCCRTC_TB_COUNT1 64000
`define MCCRTC_TB_COUNT2 160000
`define MCCRTC_TB_COUNT3 400000
`define MCCRTC_TB_WIDTH 19

// Bus responses
`define MCCRTC_RESP_OKAY 2'h0
`define MCCRTC_RESP_SLVERR 2'h2

`endif

// ### design/mccrtc_pkg.sv
package mccrtc_pkg;
    // Core power states seen by the clock controller
    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_WAIT,
        MODE_ACTIVE_HALT,
        MODE_FULL_HALT
    } mccrtc_mode_type;

    typedef logic [1:0] mccrtc_sel_type;
endpackage : mccrtc_pkg

// ### design/mccrtc_timebase.sv
`timescale 1ns/100ps
`default_nettype none
`include "mccrtc_map.svh"
module mccrtc_timebase #(
    parameter int TB_COUNT0 = `MCCRTC_TB_COUNT0,
    parameter int TB_COUNT1 = `MCCRTC_TB_COUNT1,
    parameter int TB_COUNT2 = `MCCRTC_TB_COUNT2,
    parameter int TB_COUNT3 = `MCCRTC_TB_COUNT3
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    mccrtc_ctl_if.tbase ctl
);
    import mccrtc_pkg::*;

    localparam int W = `MCCRTC_TB_WIDTH;

    logic [W-1:0] count_q;
    logic [1:0] sel_q;
    logic period_end_q;
    logic [W-1:0] last;
    logic at_end;

    // Last count value of the period for a select code
    function automatic logic [W-1:0] period_last(input logic [1:0] sel);
        case (sel)
            2'h0: period_last = W'(TB_COUNT0 - 1);                  // [R7]
            2'h1: period_last = W'(TB_COUNT1 - 1);
            2'h2: period_last = W'(TB_COUNT2 - 1);
            default: period_last = W'(TB_COUNT3 - 1);
        endcase
    endfunction : period_last

    assign last = period_last(sel_q);
    assign at_end = ctl.tb_run && (count_q == last);

    // Select latched only at the period boundary to avoid a time shift
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            count_q <= '0;
            sel_q <= 2'h0;
            period_end_q <= 1'b0;
        end else begin
            period_end_q <= at_end;
            if (at_end) begin
                count_q <= '0;
                sel_q <= ctl.tb_select;                             // [R8]
            end else if (ctl.tb_run) begin                          // [R15]
                count_q <= count_q + W'(1);
            end
        end
    end

    assign ctl.period_end = period_end_q;
endmodule : mccrtc_timebase
`default_nettype wire

// ### design/mccrtc_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "mccrtc_map.svh"
module mccrtc_top #(
    parameter int TB_COUNT0 = `MCCRTC_TB_COUNT0,
    parameter int TB_COUNT1 = `MCCRTC_TB_COUNT1,
    parameter int TB_COUNT2 = `MCCRTC_TB_COUNT2,
    parameter int TB_COUNT3 = `MCCRTC_TB_COUNT3
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // AXI4-Lite slave
    input wire logic [7:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    output logic [1:0] o_s_axi_bresp,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic [7:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    // Core side, same clock
    input wire logic i_halt_exec,
    input wire logic i_wait_exec,
    input wire logic i_other_wake,
    input wire logic i_cpu_irq_masked,
    output mccrtc_pkg::mccrtc_mode_type o_power_mode,
    output logic o_timebase_irq,
    output logic o_irq,
    // Clocks
    output logic o_cpu_clk,
    output logic o_bus_clk,
    output logic o_clk_out,
    output logic o_clk_out_oe
);
    import mccrtc_pkg::*;

    mccrtc_ctl_if ctl ();

    // Register state
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [7:0] misc_q;
    logic [7:0] misc_d;
    logic irq_status_q;
    logic irq_status_d;
    logic irq_mask_q;
    logic irq_mask_d;
    mccrtc_mode_type mode_q;
    mccrtc_mode_type mode_d;
    logic tb_irq_q;
    logic irq_q;
    logic clk_out_oe_q;

    // Bus state
    logic aw_full_q;
    logic aw_full_d;
    logic [7:0] aw_addr_q;
    logic w_full_q;
    logic w_full_d;
    logic [7:0] w_data_q;
    logic w_lane0_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    // Register select from a byte address; bit 0 of result is "mapped"
    function automatic logic [4:0] reg_sel(input logic [7:0] addr);
        reg_sel = 5'h00;
        if (addr[1:0] == 2'h0) begin
            if (addr[7:2] == `MCCRTC_IDX_MISC) reg_sel = 5'h03;
            if (addr[7:2] == `MCCRTC_IDX_CTRL) reg_sel = 5'h05;
            if (addr[7:2] == `MCCRTC_IDX_IRQ_STATUS) reg_sel = 5'h09;
            if (addr[7:2] == `MCCRTC_IDX_IRQ_MASK) reg_sel = 5'h11;
        end
    endfunction : reg_sel

    // Write path decode
    logic aw_hs;
    logic w_hs;
    logic do_write;
    logic [4:0] wsel;
    logic wr_en;
    logic frozen;
    assign aw_hs = i_s_axi_awvalid && awready_q;
    assign w_hs = i_s_axi_wvalid && wready_q;
    assign do_write = aw_full_q && w_full_q && !bvalid_q;
    assign wsel = reg_sel(aw_addr_q);
    // Bus writes to the registers are ignored in either halt
    assign frozen = (mode_q == MODE_ACTIVE_HALT) || (mode_q == MODE_FULL_HALT); // [R14] [R15]
    assign wr_en = do_write && w_lane0_q && !frozen;
    assign aw_full_d = do_write ? 1'b0 : (aw_full_q || aw_hs);
    assign w_full_d = do_write ? 1'b0 : (w_full_q || w_hs);

    // Read path decode
    logic ar_hs;
    logic [4:0] rsel;
    logic [7:0] rd_byte;
    logic ctrl_read;
    assign ar_hs = i_s_axi_arvalid && arready_q;
    assign rsel = reg_sel(i_s_axi_araddr);
    assign rd_byte = rsel[1] ? misc_q :
                     rsel[2] ? {4'h0, ctrl_q[3:0]} :                // [R12]
                     rsel[3] ? {7'h00, irq_status_q} :
                     rsel[4] ? {7'h00, irq_mask_q} : 8'h00;
    assign ctrl_read = ar_hs && rsel[2];

    // Time base event and flag; a coinciding event beats the read clear
    logic tb_event;
    logic flag_next;
    logic tb_req;
    assign tb_event = ctl.period_end;
    assign flag_next = tb_event ? 1'b1 :                            // [R17]
                       ctrl_read ? 1'b0 : ctrl_q[`MCCRTC_CTRL_FLAG]; // [R9]
    assign ctrl_d = {4'h0,
                     (wr_en && wsel[2]) ? w_data_q[3:1] : ctrl_q[3:1],
                     flag_next};
    assign misc_d = (wr_en && wsel[1]) ? (w_data_q & 8'h27) : misc_q;
    // Sticky event bit: the event wins over a write-one clear
    assign irq_status_d = tb_event ||
                          (irq_status_q && !(wr_en && wsel[3] && w_data_q[0]));
    assign irq_mask_d = (wr_en && wsel[4]) ? w_data_q[0] : irq_mask_q;
    // Request gated by flag, enable and the core's own mask
    assign tb_req = flag_next && ctrl_d[`MCCRTC_CTRL_IRQ_EN] && !i_cpu_irq_masked; // [R10]

    // Power mode sequencing
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            MODE_RUN: begin
                if (i_halt_exec) begin
                    mode_d = ctrl_q[`MCCRTC_CTRL_IRQ_EN] ? MODE_ACTIVE_HALT  // [R11]
                                                         : MODE_FULL_HALT;
                end else if (i_wait_exec) begin
                    mode_d = MODE_WAIT;
                end
            end
            MODE_WAIT: begin
                if (tb_req || i_other_wake) mode_d = MODE_RUN;      // [R13]
            end
            MODE_ACTIVE_HALT: begin
                if (tb_req || i_other_wake) mode_d = MODE_RUN;      // [R14]
            end
            MODE_FULL_HALT: begin
                if (i_other_wake) mode_d = MODE_RUN;                // [R15]
            end
            default: mode_d = MODE_RUN;
        endcase
    end

    // Control to the dividers and the time base
    assign ctl.tb_select = ctrl_q[`MCCRTC_CTRL_TB_HI:`MCCRTC_CTRL_TB_LO];
    // Counter runs in wait and active-halt, stops only in full halt
    assign ctl.tb_run = (mode_q != MODE_FULL_HALT);                 // [R13] [R14] [R15]
    assign ctl.slow_mode = misc_q[`MCCRTC_MISC_SMS];
    assign ctl.slow_div = misc_q[`MCCRTC_MISC_DIV_HI:`MCCRTC_MISC_DIV_LO];
    assign ctl.clk_out_en = misc_q[`MCCRTC_MISC_CLKOUT];
    assign ctl.clk_out_hold = frozen;                               // [R6]
    assign ctl.cpu_hold = frozen;

    mccrtc_clkdiv u_clkdiv (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .ctl(ctl.cdiv)
    );

    mccrtc_timebase #(
        .TB_COUNT0(TB_COUNT0),
        .TB_COUNT1(TB_COUNT1),
        .TB_COUNT2(TB_COUNT2),
        .TB_COUNT3(TB_COUNT3)
    ) u_timebase (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .ctl(ctl.tbase)
    );

    // Register file and mode state
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            ctrl_q <= `MCCRTC_CTRL_RESET;                           // [R12]
            misc_q <= `MCCRTC_MISC_RESET;
            irq_status_q <= 1'b0;
            irq_mask_q <= 1'b0;
            mode_q <= MODE_RUN;
            tb_irq_q <= 1'b0;
            irq_q <= 1'b0;
            clk_out_oe_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            misc_q <= misc_d;
            irq_status_q <= irq_status_d;
            irq_mask_q <= irq_mask_d;
            mode_q <= mode_d;
            tb_irq_q <= tb_req;
            irq_q <= irq_status_d && irq_mask_d;
            clk_out_oe_q <= misc_d[`MCCRTC_MISC_CLKOUT];            // [R5]
        end
    end

    // Write channel: address and data taken in either order
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 8'h00;
            w_lane0_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `MCCRTC_RESP_OKAY;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            awready_q <= !aw_full_d;
            wready_q <= !w_full_d;
            if (aw_hs) aw_addr_q <= i_s_axi_awaddr;
            if (w_hs) begin
                w_data_q <= i_s_axi_wdata[7:0];
                w_lane0_q <= i_s_axi_wstrb[0];
            end
            if (do_write) begin
                bvalid_q <= 1'b1;
                bresp_q <= wsel[0] ? `MCCRTC_RESP_OKAY : `MCCRTC_RESP_SLVERR;
            end else if (i_s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Read channel: one read at a time, the read itself clears the flag
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `MCCRTC_RESP_OKAY;
        end else begin
            if (ar_hs) begin
                arready_q <= 1'b0;
                rvalid_q <= 1'b1;
                rdata_q <= {24'h000000, rd_byte};
                rresp_q <= rsel[0] ? `MCCRTC_RESP_OKAY : `MCCRTC_RESP_SLVERR;
            end else if (rvalid_q && i_s_axi_rready) begin
                rvalid_q <= 1'b0;
                arready_q <= 1'b1;
            end else if (!rvalid_q) begin
                arready_q <= 1'b1;
            end
        end
    end

    // Software must write the register whole; no bit set/clear [R16]
    assign o_s_axi_awready = awready_q;
    assign o_s_axi_wready = wready_q;
    assign o_s_axi_bvalid = bvalid_q;
    assign o_s_axi_bresp = bresp_q;
    assign o_s_axi_arready = arready_q;
    assign o_s_axi_rvalid = rvalid_q;
    assign o_s_axi_rdata = rdata_q;
    assign o_s_axi_rresp = rresp_q;
    assign o_power_mode = mode_q;
    assign o_timebase_irq = tb_irq_q;
    assign o_irq = irq_q;
    assign o_cpu_clk = ctl.cpu_clk;
    assign o_bus_clk = ctl.bus_clk;
    assign o_clk_out = ctl.clk_out;
    assign o_clk_out_oe = clk_out_oe_q;
endmodule : mccrtc_top
`default_nettype wire

// ### testbench/mccrtc_checker.sv
`timescale 1ns/100ps
`default_nettype none
module mccrtc_checker
    import mccrtc_pkg::*;
#(
    parameter int TB_COUNT0 = 32000,
    parameter int TB_COUNT1 = 64000,
    parameter int TB_COUNT2 = 160000,
    parameter int TB_COUNT3 = 400000
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_halt_exec,
    input wire logic i_other_wake,
    input wire logic i_cpu_irq_masked,
    input wire mccrtc_pkg::mccrtc_mode_type o_power_mode,
    input wire logic o_timebase_irq,
    input wire logic o_bus_clk,
    input wire logic o_clk_out,
    input wire logic o_clk_out_oe,
    input wire logic o_s_axi_rvalid,
    input wire logic [1:0] o_s_axi_rresp,
    input wire logic [31:0] o_s_axi_rdata
);
    // Single domain, so one clock and one disable for all
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);

    AST_BUS_CLK: assert property (!$past(i_reset) && !$past(i_reset, 2) |->
        o_bus_clk != $past(o_bus_clk))
        else $error("bus clock stopped toggling");
    AST_CLKOUT_IDLE: assert property (!o_clk_out_oe && !$past(o_clk_out_oe) |-> !o_clk_out)
        else $error("clock-out active while disabled");
    AST_CLKOUT_RUN: assert property (o_clk_out_oe && $past(o_clk_out_oe, 2) && o_power_mode == MODE_RUN
        && $past(o_power_mode, 2) == MODE_RUN |-> o_clk_out != $past(o_clk_out))
        else $error("clock-out not at half oscillator rate");
    AST_CLKOUT_FROZEN: assert property (o_power_mode == MODE_ACTIVE_HALT
        && $past(o_power_mode) == MODE_ACTIVE_HALT |-> $stable(o_clk_out))
        else $error("clock-out toggled in active halt");
    AST_IRQ_MASKED: assert property ($past(i_cpu_irq_masked) |-> !o_timebase_irq)
        else $error("time base request while core mask active");
    AST_HALT_ENTRY: assert property (o_power_mode == MODE_RUN && i_halt_exec |=>
        o_power_mode inside {MODE_ACTIVE_HALT, MODE_FULL_HALT})
        else $error("halt not entered");
    AST_WAIT_EXIT: assert property ($past(o_power_mode) == MODE_WAIT
        && $rose(o_timebase_irq) |-> o_power_mode == MODE_RUN)
        else $error("time base request did not end wait");
    AST_AHALT_EXIT: assert property ($past(o_power_mode) == MODE_ACTIVE_HALT
        && $rose(o_timebase_irq) |-> o_power_mode == MODE_RUN)
        else $error("time base request did not end active halt");
    AST_FULL_HALT_HOLD: assert property (o_power_mode == MODE_FULL_HALT && !i_other_wake |=>
        o_power_mode == MODE_FULL_HALT)
        else $error("full halt left without wake source");
    AST_READ_UPPER: assert property (o_s_axi_rvalid && o_s_axi_rresp == 2'h0 |->
        o_s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read data bits not zero");
endmodule : mccrtc_checker

bind mccrtc_top mccrtc_checker #(.TB_COUNT0(TB_COUNT0), .TB_COUNT1(TB_COUNT1),
    .TB_COUNT2(TB_COUNT2), .TB_COUNT3(TB_COUNT3)) u_checker (.i_ref_clk(i_ref_clk),
    .i_reset(i_reset), .i_halt_exec(i_halt_exec), .i_other_wake(i_other_wake),
    .i_cpu_irq_masked(i_cpu_irq_masked), .o_power_mode(o_power_mode),
    .o_timebase_irq(o_timebase_irq), .o_bus_clk(o_bus_clk), .o_clk_out(o_clk_out),
    .o_clk_out_oe(o_clk_out_oe), .o_s_axi_rvalid(o_s_axi_rvalid),
    .o_s_axi_rresp(o_s_axi_rresp), .o_s_axi_rdata(o_s_axi_rdata));
`default_nettype wire

// ### testbench/mccrtc_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "mccrtc_map.svh"
module mccrtc_tb;
    import mccrtc_pkg::*;
    // Short periods keep the run small; expectations use the same table
    localparam int CNT [4] = '{200, 400, 600, 800};
    localparam logic [7:0] A_MISC = 8'(`MCCRTC_IDX_MISC * 4);
    localparam logic [7:0] A_CTRL = 8'(`MCCRTC_IDX_CTRL * 4);
    localparam logic [7:0] A_STAT = 8'(`MCCRTC_IDX_IRQ_STATUS * 4);
    localparam logic [7:0] A_MASK = 8'(`MCCRTC_IDX_IRQ_MASK * 4);
    localparam logic [1:0] OK = `MCCRTC_RESP_OKAY;
    logic clk = 1'b0, rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic halt = 1'b0, wt = 1'b0, wake = 1'b0, masked = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, tb_irq, irq, cpu_clk, bus_clk, clk_out, oe;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    mccrtc_mode_type mode;
    int fail_count = 0, n_compared = 0, cyc = 0;

    // Clock and free cycle count for period measurements
    always #5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    // Ready signals tied high: the master always accepts answers at once
    mccrtc_top #(.TB_COUNT0(CNT[0]), .TB_COUNT1(CNT[1]), .TB_COUNT2(CNT[2]),
        .TB_COUNT3(CNT[3])) dut (
        .i_ref_clk(clk), .i_reset(rst), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
        .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'h1),
        .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
        .o_s_axi_bvalid(bvalid), .i_s_axi_bready(1'b1), .i_s_axi_araddr(araddr),
        .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
        .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(1'b1),
        .i_halt_exec(halt), .i_wait_exec(wt), .i_other_wake(wake), .i_cpu_irq_masked(masked),
        .o_power_mode(mode), .o_timebase_irq(tb_irq), .o_irq(irq), .o_cpu_clk(cpu_clk),
        .o_bus_clk(bus_clk), .o_clk_out(clk_out), .o_clk_out_oe(oe));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t %s got=%h exp=%h", $time, what, got, exp);
        end
    endtask : chk

    // Whole-byte writes only, never read-modify-write
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid && n < 100);
        chk(32'({n >= 100, bresp}), 32'(er), "bresp");
    endtask : wr

    // Read data only judged on OKAY, error data is undefined
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid && n < 100);
        chk(32'({n >= 100, rresp}), 32'(er), "rresp");
        if (er == OK) chk(rdata, {24'h000000, exp}, "rdata");
    endtask : rd

    task automatic edges(input int k);
        repeat (k) @(posedge clk);
    endtask : edges

    task automatic rise(output int t);
        int n;
        n = 0;
        while (!tb_irq && n < 2000) begin
            @(posedge clk);
            n++;
        end
        t = cyc;
    endtask : rise

    task automatic pulse(input int w);
        if (w == 0) halt <= 1'b1; else if (w == 1) wt <= 1'b1; else wake <= 1'b1;
        @(posedge clk);
        halt <= 1'b0;
        wt <= 1'b0;
        wake <= 1'b0;
        @(posedge clk);
    endtask : pulse

    function automatic logic pick(input int w);
        return (w == 0) ? cpu_clk : (w == 1) ? bus_clk : clk_out;
    endfunction : pick

    // First rise skipped: a divider change may leave one odd cycle
    task automatic per(input int w, output int p);
        int t, n;
        t = 0;
        n = 0;
        for (int e = 0; e < 6; e++) begin
            while (pick(w) == !e[0] && n < 300) begin
                @(posedge clk);
                n++;
            end
            if (e == 3) t = cyc;
        end
        p = cyc - t;
    endtask : per

    task automatic t_regs();
        rd(A_CTRL, 8'h01, OK);
        rd(A_CTRL, 8'h00, OK);
        rd(A_MISC, 8'h00, OK);
        rd(8'hFC, 8'h00, `MCCRTC_RESP_SLVERR);
        wr(8'hFC, 8'h55, `MCCRTC_RESP_SLVERR);
        wr(A_CTRL, 8'hFF, OK);
        rd(A_CTRL, 8'h0E, OK);
        $display("test regs done");
    endtask : t_regs

    task automatic t_period();
        int t0, t1, t2, j, k;
        j = 0;
        wr(A_CTRL, 8'h02, OK);
        rise(t0);
        for (int i = 0; i < 4; i++) begin
            k = (j + 1) % 4;
            rd(A_CTRL, {4'h0, 2'(j), 2'b11}, OK);
            wr(A_CTRL, {4'h0, 2'(k), 2'b10}, OK);
            edges(2);
            rise(t1);
            chk(32'(t1 - t0), 32'(CNT[j]), "old period");
            rd(A_CTRL, {4'h0, 2'(k), 2'b11}, OK);
            edges(2);
            rise(t2);
            chk(32'(t2 - t1), 32'(CNT[k]), "new period");
            t0 = t2;
            j = k;
        end
        $display("test period done");
    endtask : t_period

    task automatic t_irq();
        rd(A_CTRL, 8'h03, OK);
        masked <= 1'b1;
        edges(CNT[0] + 20);
        chk(32'(tb_irq), 32'h0, "masked request");
        rd(A_CTRL, 8'h03, OK);
        masked <= 1'b0;
        wr(A_MASK, 8'h00, OK);
        edges(2);
        chk(32'(irq), 32'h0, "irq masked");
        rd(A_STAT, 8'h01, OK);
        wr(A_MASK, 8'h01, OK);
        edges(2);
        chk(32'(irq), 32'h1, "irq raised");
        wr(A_STAT, 8'h01, OK);
        edges(2);
        chk(32'(irq), 32'h0, "irq cleared");
        rd(A_STAT, 8'h00, OK);
        $display("test irq done");
    endtask : t_irq

    task automatic t_clocks();
        logic [7:0] v [5] = '{8'h21, 8'h25, 8'h23, 8'h27, 8'h20};
        int ex [5] = '{4, 8, 16, 32, 2};
        int p;
        for (int i = 0; i < 5; i++) begin
            wr(A_MISC, v[i], OK);
            rd(A_MISC, v[i], OK);
            per(0, p);
            chk(32'(p), 32'(ex[i]), "cpu clock");
            per(1, p);
            chk(32'(p), 32'h2, "bus clock");
            per(2, p);
            chk(32'(p), 32'h2, "clock-out");
            chk(32'(oe), 32'h1, "clock-out enable");
        end
        $display("test clocks done");
    endtask : t_clocks

    task automatic t_modes();
        int t;
        rise(t);
        rd(A_CTRL, 8'h03, OK);
        pulse(0);
        chk(32'(mode), 32'(MODE_ACTIVE_HALT), "active halt");
        wr(A_CTRL, 8'h0E, OK);
        rise(t);
        edges(2);
        chk(32'(mode), 32'(MODE_RUN), "active halt exit");
        rd(A_CTRL, 8'h03, OK);
        wr(A_CTRL, 8'h00, OK);
        pulse(0);
        chk(32'(mode), 32'(MODE_FULL_HALT), "full halt");
        edges(2 * CNT[0]);
        chk(32'(mode), 32'(MODE_FULL_HALT), "full halt held");
        pulse(2);
        chk(32'(mode), 32'(MODE_RUN), "full halt exit");
        wr(A_CTRL, 8'h02, OK);
        rise(t);
        rd(A_CTRL, 8'h03, OK);
        pulse(1);
        chk(32'(mode), 32'(MODE_WAIT), "wait");
        rise(t);
        edges(2);
        chk(32'(mode), 32'(MODE_RUN), "wait exit");
        $display("test modes done");
    endtask : t_modes

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : finish_test

    // Main sequence after a 16-cycle reset
    initial begin
        edges(16);
        rst <= 1'b0;
        edges(1);
        t_regs();
        t_period();
        t_irq();
        t_clocks();
        t_modes();
        finish_test();
    end

    // Watchdog well beyond the expected run length
    initial begin
        edges(40000);
        fail_count++;
        finish_test();
    end
endmodule : mccrtc_tb
`default_nettype wire
